/* File: logic/shr_top.sv */
// Serial channel: sync pattern, expedite transmit, HDLC receive errors.
// Assumes AHB-Lite master on sys_clk_in; line clocks come from pins.
`timescale 1ns/10ps
module shr_top
   import shr_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hwdata_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // Serial line pins
   input  wire logic        tx_clk_in,
   input  wire logic        rx_clk_in,
   input  wire logic        rx_data_in,
   input  wire logic        carrier_in,
   output logic             tx_data_out,
   // Descriptor side
   input  wire logic        bd_ready_in,   // Next tx descriptor ready
   input  wire logic        addr_miss_in,  // Address recognition failed
   output logic             rx_frame_event_out
);
   typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA} shr_txs_t;
   typedef enum logic [1:0] {RX_HUNT, RX_FRAME} shr_rxs_t;
   typedef struct packed {
      logic        ap_vld;      // Pending data phase
      logic        ap_wr;
      logic [7:0]  ap_ofs;
      logic [31:0] rdata;
      logic [15:0] sync;        // Sync pattern register
      logic        exp;         // Expedite bit
      logic        exp_seen;    // Tx clock edge seen since set
      logic [7:0]  mode;
      logic [7:0]  rstat;       // Closed buffer status
      logic [15:0] abcnt;       // Abort counter
      logic [31:0] rword;       // Last buffer word
      logic [15:0] rlen;
      logic [7:0]  txbyte;
      shr_txs_t    txs;
      logic [5:0]  poll;
      logic [3:0]  tbit;
      logic        tline;
      shr_rxs_t    rxs;
      logic [1:0]  nbytes;      // Bytes in fifo word
      logic        fifo_full;   // Word not yet drained
      logic        rxev;
      logic        carr_prev;   // Carrier level one cycle ago
   } shr_st_t;
   shr_st_t st_ff;
   shr_st_t nxt_st;
   // Synchronised line signals
   logic tclk_rise;
   logic rclk_rise;
   logic rdat_lvl;
   logic carr_lvl;
   logic fl;
   logic ab;
   logic by;
   logic [7:0] rbyte;
   logic [2:0] nb;
   // Tx and rx clock edge finders; rx data and carrier synchronisers
   shr_edge u_tclk (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .pin_in     (tx_clk_in),
      .level_out  (),
      .rise_out   (tclk_rise)
   );
   shr_edge u_rclk (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .pin_in     (rx_clk_in),
      .level_out  (),
      .rise_out   (rclk_rise)
   );
   shr_edge u_rdat (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .pin_in     (rx_data_in),
      .level_out  (rdat_lvl),
      .rise_out   ()
   );
   shr_edge u_carr (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .pin_in     (carrier_in),
      .level_out  (carr_lvl),
      .rise_out   ()
   );
   // Bit level receiver
   shr_rx u_rx (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .bit_stb_in (rclk_rise),
      .bit_in     (rdat_lvl),
      .flag_out   (fl),
      .abort_out  (ab),
      .byte_out   (by),
      .data_out   (rbyte),
      .nbits_out  (nb)
   );
   // Next state
   always_comb begin
      logic [31:0] wd;
      logic [7:0]  lastb;
      wd     = '0;
      lastb  = '0;
      nxt_st = st_ff;
      nxt_st.rxev = 1'b0;
      nxt_st.carr_prev = carr_lvl;   // Carrier history, for loss detect
      // AHB address phase captured
      nxt_st.ap_vld = hsel_in & hready_in & htrans_in[1];
      nxt_st.ap_wr  = hwrite_in;
      nxt_st.ap_ofs = haddr_in[7:0];
      // Read data for the coming data phase
      unique case (haddr_in[7:0])
         SHR_SYNC_OFS:  nxt_st.rdata = {16'h0000, st_ff.sync};
         SHR_EXP_OFS:   nxt_st.rdata = {16'h0000, st_ff.exp, 15'h0000};
         SHR_MODE_OFS:  nxt_st.rdata = {24'h000000, st_ff.mode};
         SHR_STAT_OFS:  nxt_st.rdata = {16'h0000, st_ff.rlen[7:0], st_ff.rstat};
         SHR_ABCNT_OFS: nxt_st.rdata = {16'h0000, st_ff.abcnt};
         SHR_RXDAT_OFS: nxt_st.rdata = st_ff.rword;
         SHR_TXDAT_OFS: nxt_st.rdata = {24'h000000, st_ff.txbyte};
         default:       nxt_st.rdata = 32'h00000000;
      endcase
      // Reading the data word drains the fifo word
      if (st_ff.ap_vld && !st_ff.ap_wr && st_ff.ap_ofs == SHR_RXDAT_OFS) begin
         nxt_st.fifo_full = 1'b0;
      end
      // Write data phase
      if (st_ff.ap_vld && st_ff.ap_wr) begin
         unique case (st_ff.ap_ofs)
            SHR_SYNC_OFS: nxt_st.sync = hwdata_in[15:0];
            SHR_EXP_OFS: begin
               nxt_st.exp      = hwdata_in[SHR_EXP_BIT];
               nxt_st.exp_seen = 1'b0;
            end
            SHR_MODE_OFS:  nxt_st.mode   = hwdata_in[7:0];
            SHR_STAT_OFS:  nxt_st.rstat  = st_ff.rstat & ~hwdata_in[7:0];
            SHR_TXDAT_OFS: nxt_st.txbyte = hwdata_in[7:0];
            default: ;
         endcase
      end
      // Transmitter on tx clock edges
      if (tclk_rise && st_ff.mode[SHR_MODE_TXEN]) begin
         // Expedite bit cleared one serial clock later
         // A write landing in this cycle wins over the self-clear
         if (st_ff.exp && !(st_ff.ap_vld && st_ff.ap_wr && st_ff.ap_ofs == SHR_EXP_OFS)) begin
            nxt_st.exp_seen = 1'b1;
            if (st_ff.exp_seen) begin
               nxt_st.exp = 1'b0;
            end
         end
         unique case (st_ff.txs)
            TX_IDLE: begin
               nxt_st.tline = st_ff.mode[SHR_MODE_ASYNC] ? 1'b1 : st_ff.tline;
               nxt_st.poll  = st_ff.poll + 6'd1;
               // Periodic poll, or at once on expedite
               if (st_ff.exp || st_ff.poll >= (st_ff.mode[SHR_MODE_PSLOW] ?
                                             SHR_POLL_SLOW : SHR_POLL_FAST) - 6'd1) begin
                  nxt_st.poll = 6'd0;
                  if (bd_ready_in) begin
                     nxt_st.txs  = TX_SYNC;
                     nxt_st.tbit = 4'd0;
                  end
               end
            end
            TX_SYNC: begin
               // Sync pattern LSB first; in async mode low bits set stop fraction
               nxt_st.tline = st_ff.sync[st_ff.tbit];
               nxt_st.tbit  = st_ff.tbit + 4'd1;
               if (st_ff.tbit == (st_ff.mode[SHR_MODE_ASYNC] ? 4'd3 : 4'd15)) begin
                  nxt_st.txs  = TX_DATA;
                  nxt_st.tbit = 4'd0;
               end
            end
            TX_DATA: begin
               nxt_st.tline = st_ff.txbyte[st_ff.tbit[2:0]];
               nxt_st.tbit  = st_ff.tbit + 4'd1;
               if (st_ff.tbit == 4'd7) begin
                  nxt_st.tbit = 4'd0;
                  // Next ready descriptor follows with no poll
                  nxt_st.txs  = bd_ready_in ? TX_DATA : TX_IDLE;
               end
            end
            default: nxt_st.txs = TX_IDLE;
         endcase
      end
      // Receiver; carrier loss first, highest priority
      if (st_ff.mode[SHR_MODE_RXEN]) begin
         unique case (st_ff.rxs)
            RX_HUNT: begin
               if (fl) begin
                  nxt_st.rxs    = RX_FRAME;
                  nxt_st.rlen   = '0;
                  nxt_st.nbytes = 2'd0;
               end
               // Abort while hunting is silent
            end
            RX_FRAME: begin
               if (st_ff.carr_prev && !carr_lvl) begin
                  nxt_st.rstat[SHR_ST_CARR] = 1'b1;
                  nxt_st.rstat[SHR_ST_DONE] = 1'b1;
                  nxt_st.rxev = st_ff.mode[SHR_MODE_EVEN];
                  nxt_st.rxs  = RX_HUNT;
               end else if (ab) begin
                  nxt_st.rstat[SHR_ST_KILL] = 1'b1;
                  nxt_st.rstat[SHR_ST_DONE] = 1'b1;
                  nxt_st.abcnt = st_ff.abcnt + 16'd1;
                  nxt_st.rxev  = st_ff.mode[SHR_MODE_EVEN];
                  nxt_st.rxs   = RX_HUNT;
               end else if (by && st_ff.fifo_full && st_ff.nbytes == 2'd0) begin
                  // New byte over an undrained word: overwrite
                  nxt_st.rword[7:0] = rbyte;
                  nxt_st.rstat[SHR_ST_LOST] = 1'b1;
                  nxt_st.rstat[SHR_ST_DONE] = 1'b1;
                  // Mismatched address still reports length two
                  if (st_ff.mode[SHR_MODE_NOMATCH] || addr_miss_in) begin
                     nxt_st.rlen = SHR_OVR_LEN;
                  end
                  nxt_st.rxev = st_ff.mode[SHR_MODE_EVEN];
                  nxt_st.rxs  = RX_HUNT;
               end else if (by) begin
                  // Pack bytes; start handing over after 8 or 32 bits
                  nxt_st.rword = {st_ff.rword[23:0], rbyte};
                  nxt_st.rlen  = st_ff.rlen + 16'd1;
                  nxt_st.nbytes = st_ff.nbytes + 2'd1;
                  if (!st_ff.mode[SHR_MODE_WIDE] || st_ff.nbytes == 2'd3) begin
                     nxt_st.fifo_full = 1'b1;
                     nxt_st.nbytes    = 2'd0;
                  end
               end else if (fl && (st_ff.rlen != 16'd0 || nb != 3'd0)) begin
                  // Flags with nothing between them only fill the line
                  nxt_st.rstat[SHR_ST_DONE] = 1'b1;
                  nxt_st.rxev = st_ff.mode[SHR_MODE_EVEN];
                  if (nb != 3'd0) begin
                     // Valid bits high, one marker, zeros below
                     lastb = (rbyte & (8'hff << (4'd8 - {1'b0, nb}))) | (8'h80 >> nb);
                     wd    = {st_ff.rword[23:0], lastb};
                     if (!st_ff.mode[SHR_MODE_SWAP]) begin
                        wd = {lastb, st_ff.rword[31:8]};   // Last byte
                     end
                     nxt_st.rword = wd;
                     nxt_st.rstat[SHR_ST_NOOCT] = 1'b1;
                  end
                  // Closing flag may open the next frame back to back
                  nxt_st.rxs  = RX_FRAME;
                  nxt_st.rlen = '0;
                  nxt_st.nbytes = 2'd0;
               end
            end
            default: nxt_st.rxs = RX_HUNT;
         endcase
      end
      nxt_st.rstat[SHR_ST_READY] = bd_ready_in;
      nxt_st.rstat[SHR_ST_TXBSY] = (st_ff.txs != TX_IDLE);
   end
   // State register, frozen by clock enable
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         st_ff       <= '0;
         st_ff.sync  <= SHR_SYNC_RST;
         st_ff.exp   <= SHR_EXP_RST[SHR_EXP_BIT];
         st_ff.mode  <= SHR_MODE_RST;
         st_ff.tline <= 1'b1;
         st_ff.txs   <= TX_IDLE;
         st_ff.rxs   <= RX_HUNT;
      end else if (ce_in) begin
         st_ff <= nxt_st;
      end
   end
   // Zero-wait slave, always OKAY
   assign hrdata_out         = st_ff.rdata;
   assign hreadyout_out      = 1'b1;
   assign hresp_out          = 1'b0;
   assign tx_data_out        = st_ff.tline;
   assign rx_frame_event_out = st_ff.rxev;
endmodule // shr_top

/* File: pkg/shr_pkg.sv */
// Package for the serial channel sync/expedite/HDLC receive error block.
// Assumes a single 32-bit AHB-Lite slave on a 10 MHz system clock.
package shr_pkg;
   // Register byte offsets
   localparam logic [7:0]  SHR_SYNC_OFS   = 8'h00;
   localparam logic [7:0]  SHR_EXP_OFS    = 8'h04;
   localparam logic [7:0]  SHR_MODE_OFS   = 8'h08;
   localparam logic [7:0]  SHR_STAT_OFS   = 8'h0c;
   localparam logic [7:0]  SHR_ABCNT_OFS  = 8'h10;
   localparam logic [7:0]  SHR_RXDAT_OFS  = 8'h14;
   localparam logic [7:0]  SHR_TXDAT_OFS  = 8'h18;
   // Reset values
   localparam logic [15:0] SHR_SYNC_RST   = 16'h7e7e;
   localparam logic [15:0] SHR_EXP_RST    = 16'h0000;
   localparam logic [7:0]  SHR_MODE_RST   = 8'h00;
   // Field positions
   localparam int SHR_EXP_BIT     = 15;
   localparam int SHR_MODE_WIDE   = 0;   // Rx fifo width 32
   localparam int SHR_MODE_ASYNC  = 1;   // Async char mode
   localparam int SHR_MODE_SWAP   = 2;   // Byte order bit cleared: swap
   localparam int SHR_MODE_RXEN   = 3;
   localparam int SHR_MODE_TXEN   = 4;
   localparam int SHR_MODE_PSLOW  = 5;   // Slow poll (32 instead of 8)
   localparam int SHR_MODE_EVEN   = 6;   // Frame event enable
   localparam int SHR_MODE_NOMATCH = 7;  // Address mismatch seen
   // Status bits
   localparam int SHR_ST_LOST  = 0;
   localparam int SHR_ST_CARR  = 1;
   localparam int SHR_ST_KILL  = 2;
   localparam int SHR_ST_NOOCT = 3;
   localparam int SHR_ST_DONE  = 4;
   localparam int SHR_ST_READY = 5;
   localparam int SHR_ST_TXBSY = 6;
   // Timing counts, in serial clocks; overrun length and flag pattern
   localparam logic [5:0] SHR_POLL_FAST = 6'd8;
   localparam logic [5:0] SHR_POLL_SLOW = 6'd32;
   localparam logic [2:0] SHR_ABORT_ONES = 3'd7;
   localparam logic [15:0] SHR_OVR_LEN = 16'h0002;
   localparam logic [7:0] SHR_FLAG = 8'h7e;
endpackage

/* File: logic/shr_edge.sv */
// Two-flop synchroniser with rising edge detect for a pin input.
// Assumes pin changes slowly relative to sys_clk_in.
`timescale 1ns/10ps
module shr_edge
   import shr_pkg::*;
(
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   input  wire logic pin_in,
   output logic      level_out,
   output logic      rise_out
);
   typedef struct packed {
      logic s1;   // First stage, read only by s2
      logic s2;
      logic s3;   // Previous level for edge detect
   } shr_edge_t;
   shr_edge_t st_ff;
   shr_edge_t nxt_st;
   // Shift chain
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = pin_in;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
   end
   // Register, frozen by clock enable
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         st_ff <= '0;
      end else if (ce_in) begin
         st_ff <= nxt_st;
      end
   end
   assign level_out = st_ff.s2;
   assign rise_out  = st_ff.s2 & ~st_ff.s3;
endmodule // shr_edge

/* File: logic/shr_rx.sv */
// HDLC bit receiver: flag, zero deletion, abort and octet assembly.
// Assumes bit strobes already synchronised to sys_clk_in.
`timescale 1ns/10ps
module shr_rx
   import shr_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   input  wire logic       bit_stb_in,   // One per received bit
   input  wire logic       bit_in,
   output logic            flag_out,     // Flag seen, pulse
   output logic            abort_out,    // Seven ones, pulse
   output logic            byte_out,     // Octet complete, pulse
   output logic [7:0]      data_out,
   output logic [2:0]      nbits_out     // Bits held since last octet
);
   typedef struct packed {
      logic [2:0] ones;   // Run of ones
      logic [6:0] pend;   // Held back bits, newest high
      logic [2:0] pv;     // Held back bit count
      logic [7:0] dat;    // Destuffed assembly
      logic [2:0] cnt;
      logic       flag;
      logic       abort;
      logic       byt;
      logic       abdone; // Abort already reported in this run
   } shr_rx_t;
   shr_rx_t st_ff;
   shr_rx_t nxt_st;
   // Bit processing
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.flag  = 1'b0;
      nxt_st.abort = 1'b0;
      nxt_st.byt   = 1'b0;
      if (bit_stb_in) begin
         if (bit_in) begin
            nxt_st.ones = (st_ff.ones == SHR_ABORT_ONES) ? st_ff.ones : st_ff.ones + 3'd1;
            if (st_ff.ones == 3'd6 && !st_ff.abdone) begin
               nxt_st.abort  = 1'b1;
               nxt_st.abdone = 1'b1;
            end
         end else begin
            nxt_st.ones   = 3'd0;
            nxt_st.abdone = 1'b0;
         end
         if (!bit_in && st_ff.ones == 3'd6) begin
            nxt_st.flag = 1'b1;        // Closing or opening flag
            nxt_st.pv   = 3'd0;        // Held bits were the flag; count kept for this pulse
         end else if (!bit_in && st_ff.ones == 3'd5) begin
            // Stuffed zero dropped
         end else begin
            // Data LSB first; seven bits held back, they may become a flag
            nxt_st.pend = {bit_in, st_ff.pend[6:1]};
            if (st_ff.pv != 3'd7) begin
               nxt_st.pv  = st_ff.pv + 3'd1;
               nxt_st.cnt = 3'd0;      // Count restarts behind a flag
            end else begin
               nxt_st.dat = {st_ff.pend[0], st_ff.dat[7:1]};
               nxt_st.cnt = st_ff.cnt + 3'd1;
               nxt_st.byt = (st_ff.cnt == 3'd7);
            end
         end
      end
   end
   // State register
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         st_ff <= '0;
      end else if (ce_in) begin
         st_ff <= nxt_st;
      end
   end
   assign flag_out  = st_ff.flag;
   assign abort_out = st_ff.abort;
   assign byte_out  = st_ff.byt;
   assign data_out  = st_ff.dat;
   assign nbits_out = st_ff.cnt;
endmodule // shr_rx

/* File: test/shr_top_properties.sv */
// Checker for shr_top: bus answer, sync shadow, frame event, expedite start.
// Sees only the top ports; bound into every shr_top.
`timescale 1ns/10ps
module shr_top_properties
   import shr_pkg::*;
(
   input wire logic        sys_clk_in,
   input wire logic        rst_n_in,
   input wire logic        ce_in,
   input wire logic        hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic [2:0]  hsize_in,
   input wire logic        hready_in,
   input wire logic [31:0] hwdata_in,
   input wire logic [31:0] hrdata_out,
   input wire logic        hreadyout_out,
   input wire logic        hresp_out,
   input wire logic        tx_clk_in,
   input wire logic        rx_clk_in,
   input wire logic        rx_data_in,
   input wire logic        carrier_in,
   input wire logic        tx_data_out,
   input wire logic        bd_ready_in,
   input wire logic        addr_miss_in,
   input wire logic        rx_frame_event_out
);
   // Shadow of the bus phase and of written registers
   typedef struct packed {
      logic        ap_v;   // Data phase due
      logic        ap_w;   // It is a write
      logic [7:0]  ap_a;   // Its offset
      logic [15:0] sync;   // Sync pattern as written
      logic [7:0]  mode;   // Mode as written
   } shr_chk_t;
   shr_chk_t st_ff;
   shr_chk_t nxt_st;
   logic     wr_now;    // Write data phase ends here
   logic     rd_now;    // Read data phase ends here
   // Next shadow; a write lands at the data edge, as in the block
   always_comb begin
      nxt_st = st_ff;
      wr_now = st_ff.ap_v & st_ff.ap_w;
      rd_now = st_ff.ap_v & ~st_ff.ap_w;
      nxt_st.ap_v = hsel_in & hready_in & htrans_in[1];
      nxt_st.ap_w = hwrite_in;
      nxt_st.ap_a = haddr_in[7:0];
      if (wr_now && st_ff.ap_a == SHR_SYNC_OFS) begin
         nxt_st.sync = hwdata_in[15:0];
      end
      if (wr_now && st_ff.ap_a == SHR_MODE_OFS) begin
         nxt_st.mode = hwdata_in[7:0];
      end
      // Reset wins over any bus traffic
      if (!rst_n_in) begin
         nxt_st = '0;
         nxt_st.sync = SHR_SYNC_RST;
      end
   end
   // Shadow register
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || ce_in) begin   // Frozen with the block
         st_ff <= nxt_st;
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
      else $error("Bus answer not zero-wait OKAY");
   AST_RST_VALUES: assert property ($rose(rst_n_in) |-> hrdata_out == '0
      && tx_data_out && !rx_frame_event_out) else $error("Outputs off reset values");
   AST_SYNC_READ: assert property (rd_now && st_ff.ap_a == SHR_SYNC_OFS
      |-> hrdata_out == {16'h0, st_ff.sync}) else $error("Sync read differs");
   AST_UNMAPPED: assert property (rd_now && st_ff.ap_a > SHR_TXDAT_OFS
      |-> hrdata_out == '0) else $error("Unmapped read not zero");
   AST_EV_GAP: assert property (rx_frame_event_out |=>
      !rx_frame_event_out [*8]) else $error("Frame event not a lone pulse");
   AST_EV_EN: assert property (rx_frame_event_out |->
      st_ff.mode[SHR_MODE_EVEN]) else $error("Frame event while disabled");
   AST_TX_IDLE: assert property (!st_ff.mode[SHR_MODE_TXEN] |-> tx_data_out)
      else $error("Line driven with transmitter off");
   AST_EXP_START: assert property (wr_now && st_ff.ap_a == SHR_EXP_OFS
      && hwdata_in[SHR_EXP_BIT] && bd_ready_in && st_ff.mode[SHR_MODE_TXEN]
      |-> ##[1:80] !tx_data_out) else $error("Expedited frame late");
   // Main scenarios reached
   cover property (rx_frame_event_out);
   cover property (wr_now && st_ff.ap_a == SHR_EXP_OFS);
   cover property (rd_now && st_ff.ap_a > SHR_TXDAT_OFS);
endmodule // shr_top_properties

bind shr_top shr_top_properties u_shr_top_properties (.*);

/* File: test/shr_peer.sv */
// Far station model: sends HDLC bits on its own 800 ns line clock.
// Assumes the receiver samples on the rising line clock edge.
`timescale 1ns/10ps
module shr_peer (
   output logic rx_clk_out,    // Stands low between frames
   output logic rx_data_out,   // Line data
   output logic carrier_out    // Carrier present
);
   int ones_q = 0;  // Run of ones, for zero insertion
   initial begin
      rx_clk_out = 1'b0;
      rx_data_out = 1'b1;
      carrier_out = 1'b1;
   end
   // One bit: data set half a period before the rising edge
   task automatic put_bit(input logic b);
      rx_data_out = b;
      #400 rx_clk_out = 1'b1;
      #400 rx_clk_out = 1'b0;
   endtask
   // Low bit first; zero after five ones only inside frame data
   task automatic send_bits(input logic [7:0] d, input int n, input logic stuff);
      for (int i = 0; i < n; i++) begin
         put_bit(d[i]);
         ones_q = d[i] ? ones_q + 1 : 0;
         if (stuff && ones_q == 5) begin
            put_bit(1'b0);
            ones_q = 0;
         end
      end
   endtask
   // Carrier level, may drop in mid frame
   task automatic set_carrier(input logic c);
      carrier_out = c;
   endtask
   // Line released with no pull: show the inverse of the last bit
   task automatic idle();
      rx_data_out = ~rx_data_out;
      ones_q = 0;
   endtask
endmodule // shr_peer

/* File: test/tb.sv */
// Bench for shr_top: registers over AHB-Lite, expedite start, receive errors.
// Assumes shr_peer as far station; the transmit line clock is made here.
`timescale 1ns/10ps
module tb;
   import shr_pkg::*;
   typedef struct packed {
      logic [7:0]  a;    // Offset
      logic [31:0] wd;   // Written
      logic [31:0] ex;   // Read back
   } shr_row_t;
   // Sync both ways, an unmapped place, sync restored
   shr_row_t    rows [4] = '{'{SHR_SYNC_OFS, 32'h0000d555, 32'h0000d555},
                            '{SHR_SYNC_OFS, 32'h0000a5c3, 32'h0000a5c3},
                            '{8'h1c, 32'hffffffff, 32'h00000000},
                            '{SHR_SYNC_OFS, 32'h00007e7e, 32'h00007e7e}};
   logic        clk = 1'b0;       // System clock
   logic        rst_n = 1'b0;     // Reset, active low
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = '0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic        tx_clk = 1'b0;    // Transmit line clock
   logic        bd_ready = 1'b0;  // Descriptor ready level
   logic        ce = 1'b1;        // Clock enable
   logic        addr_miss = 1'b0; // Address recognition failed
   logic [31:0] rd;               // Last read data
   int          err_total = 0;
   int          n_compared = 0;
   int          n_ev = 0;         // Frame events seen
   wire  [31:0] hrdata;
   wire         hready, hresp, rx_clk, rx_data, carrier, tx_data, ev;
   shr_top u_shr_top (
      .sys_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .hsel_in(1'b1),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
      .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .tx_clk_in(tx_clk),
      .rx_clk_in(rx_clk), .rx_data_in(rx_data), .carrier_in(carrier),
      .tx_data_out(tx_data), .bd_ready_in(bd_ready), .addr_miss_in(addr_miss),
      .rx_frame_event_out(ev));
   shr_peer u_shr_peer (.rx_clk_out(rx_clk), .rx_data_out(rx_data), .carrier_out(carrier));
   // Clocks; the line clock runs off phase to the system clock
   always #50 clk = ~clk;
   initial begin
      #137;
      forever #400 tx_clk = ~tx_clk;
   end
   // Count frame events where they are settled
   always @(negedge clk) begin
      if (ev === 1'b1) begin
         n_ev++;
      end
   end
   // Value compare, four-state
   task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string nm);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Bounded wait for hready, sampled at the rising edge
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (hready !== 1'b1) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   // One single word transfer; entered just after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
   // Verdict and end of run
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      int ev0;
      int eb [4];
      eb = '{SHR_ST_KILL, SHR_ST_CARR, SHR_ST_NOOCT, SHR_ST_LOST};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      ahb(1'b0, SHR_SYNC_OFS, '0);
      chk({16'h0, SHR_SYNC_RST}, rd, "sync reset");
      foreach (rows[i]) begin
         ahb(1'b1, rows[i].a, rows[i].wd);
         ahb(1'b0, rows[i].a, '0);
         chk(rows[i].ex, rd, "register row");
      end
      ce <= 1'b0;  // Frozen block must drop this write
      ahb(1'b1, SHR_SYNC_OFS, 32'h00001234);
      ce <= 1'b1;
      ahb(1'b0, SHR_SYNC_OFS, '0);
      chk({16'h0, SHR_SYNC_RST}, rd, "frozen write");
      $display("test registers done");
      // Slow polling, so only the expedite can start the frame this early
      ahb(1'b1, SHR_MODE_OFS, 32'h00000078);  // Other mode bits zero
      bd_ready <= 1'b1;
      ahb(1'b1, SHR_EXP_OFS, 32'h00008000);
      for (int k = 0; k < 80 && tx_data !== 1'b0; k++) begin
         @(negedge clk);
      end
      chk(32'h0, {31'h0, tx_data}, "first frame bit");
      if (tx_data !== 1'b0) tally_and_finish();
      @(posedge clk);
      bd_ready <= 1'b0;
      ahb(1'b0, SHR_EXP_OFS, '0);
      chk(32'h0, rd & 32'h00008000, "expedite clear");
      $display("test expedite done");
      // Abort, carrier loss, a short last octet, then overrun
      for (int s = 0; s < 4; s++) begin
         ev0 = n_ev;
         addr_miss <= (s == 3);
         u_shr_peer.send_bits(SHR_FLAG, 8, 1'b0);
         u_shr_peer.send_bits(8'ha5, 8, 1'b1);
         if (s == 0) u_shr_peer.send_bits(8'hff, 8, 1'b0);
         if (s == 1) u_shr_peer.set_carrier(1'b0);
         if (s == 2) u_shr_peer.send_bits(8'h05, 3, 1'b1);
         if (s == 2) u_shr_peer.send_bits(SHR_FLAG, 8, 1'b0);
         if (s == 3) repeat (2) u_shr_peer.send_bits(8'ha5, 8, 1'b1);
         u_shr_peer.idle();
         repeat (40) @(posedge clk);
         ahb(1'b0, SHR_STAT_OFS, '0);
         chk(32'h1 << eb[s], rd & 32'h0000000f, "error flag");
         chk(32'(ev0 + 1), 32'(n_ev), "frame event");
         if (s == 3) chk(32'(SHR_OVR_LEN), (rd >> 8) & 32'hff, "overrun length");
         u_shr_peer.set_carrier(1'b1);
         ahb(1'b1, SHR_STAT_OFS, 32'h0000001f);
         ahb(1'b0, SHR_RXDAT_OFS, '0);  // Drain the word
         if (s == 2) chk(32'hb0, 32'(rd[31:24]), "nonoctet last byte");
      end
      ahb(1'b0, SHR_ABCNT_OFS, '0);
      chk(32'h1, rd, "abort count");
      $display("test receive errors done");
      // Ones with no frame open leave no trace
      ev0 = n_ev;
      u_shr_peer.send_bits(8'hff, 8, 1'b0);
      u_shr_peer.send_bits(8'hff, 4, 1'b0);
      u_shr_peer.idle();
      repeat (40) @(posedge clk);
      ahb(1'b0, SHR_ABCNT_OFS, '0);
      chk(32'h1, rd, "idle abort count");
      chk(32'(ev0), 32'(n_ev), "idle abort event");
      $display("test idle abort done");
      tally_and_finish();
   end
endmodule // tb
